// ===== dv/qdud_host_model.sv
// Purpose: host writing update words
// Assumes: one word per strobe cycle
// Notes: released word shows its inverse
`timescale 1ns/1ps
module qdud_host_model
   import qdud_pkg::*;
(
   // clock and word out
   input  wire logic core_clk,
   output qdud_word_t channel_update_word = 16'hffff,
   output logic       update_strobe = 1'b0
);
   task automatic put(input qdud_word_t w, input logic s);
      @(negedge core_clk);
      channel_update_word = s ? w : ~channel_update_word;
      update_strobe = s;
   endtask
endmodule

// ===== dv/qdud_top_checker.sv
// Purpose: port checks
// Assumes: two cycle latency
// Notes: bind below
`timescale 1ns/1ps
module qdud_top_checker
   import qdud_pkg::*;
(
   // clock and inputs
   input wire logic         core_clk,
   input wire logic         rst,
   input wire qdud_word_t   channel_update_word,
   input wire logic         update_strobe,
   input wire logic [11:0]  range_cfg,
   // outputs
   input wire qdud_sample_t chan1_code,
   input wire qdud_sample_t chan2_code,
   input wire logic [3:0]   chan_loaded,
   input wire logic [3:0]   chan_is_current,
   input wire logic         range_conflict
);
   // delayed strobe, word, range
   logic [57:0] p;
   always_ff @(posedge core_clk)
      p <= {p[28:0], update_strobe & ~rst, channel_update_word, range_cfg};
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_ch1_load: assert property (p[57] && !p[53] |-> chan1_code == p[52:41]) else $error("ch1");
   a_ch2_hold: assert property (!(p[57] && !p[54]) |-> $stable(chan2_code)) else $error("ch2");
   a_sel_map: assert property (p[57] |-> chan_loaded == ~p[56:53]) else $error("sel");
   a_no_update: assert property (!p[57] |-> chan_loaded == 4'h0) else $error("idle");
   a_same_data: assert property (p[57] && p[54:53] == 2'h0 |-> chan1_code == chan2_code) else $error("same");
   a_data_field: assert property (chan_loaded[1] |-> chan2_code == p[52:41]) else $error("data");
   a_cur_range: assert property (chan_is_current[0] == (p[31:29] == 3'h0)) else $error("cur");
   a_range_mix: assert property (p[31:29] == 3'h1 && p[34:32] == 3'h0 |-> range_conflict) else $error("mix");
endmodule
bind qdud_top qdud_top_checker qdud_top_checker_i (.core_clk, .rst, .channel_update_word, .update_strobe,
   .range_cfg, .chan1_code, .chan2_code, .chan_loaded, .chan_is_current, .range_conflict);

// ===== dv/quad_dac_update_word_decoder_test.sv
// Purpose: bench for qdud_top
// Assumes: model drives words
// Notes: fixed waits
`timescale 1ns/1ps
module quad_dac_update_word_decoder_test
   import qdud_pkg::*;
();
   logic         core_clk = 1'b0, rst = 1'b1, update_strobe, range_conflict;
   logic [11:0]  range_cfg = 12'h000;
   qdud_word_t   channel_update_word;
   qdud_sample_t chan1_code, chan2_code, chan3_code, chan4_code;
   logic [3:0]   chan_loaded, chan_is_current;
   int           bad_count = 0, compares = 0;
   initial forever #2.5 core_clk = ~core_clk;
   qdud_host_model qdud_host_model_i (.core_clk, .channel_update_word, .update_strobe);
   qdud_top qdud_top_i (.core_clk, .rst, .channel_update_word, .update_strobe, .range_cfg, .chan1_code,
      .chan2_code, .chan3_code, .chan4_code, .chan_loaded, .chan_is_current, .range_conflict);
   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      compares++;
      bad_count += int'(s !== e);
      if (s !== e) $display("MISMATCH %s exp %h seen %h", n, e, s);
   endtask
   task automatic upd(input qdud_word_t w [3], input logic [47:0] e);
      foreach (w[i]) qdud_host_model_i.put(w[i], 1'b1);
      qdud_host_model_i.put(16'h0000, 1'b0);
      repeat (4) @(negedge core_clk);
      chk("codes", {chan4_code, chan3_code, chan2_code, chan1_code}, e);
   endtask
   task automatic complete_run;
      $display("TB: compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (1000) @(posedge core_clk);
      bad_count++;
      complete_run();
   end
   initial
   begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      chk("range", {chan_is_current, range_conflict}, 48'h1e);
      upd('{16'he123, 16'hffff, 16'hffff}, 48'h000000000123);
      upd('{16'h0fff, 16'hd456, 16'h7abc}, 48'habcfff456fff);
      upd('{16'hf000, 16'hb000, 16'hffff}, 48'habc000456fff);
      range_cfg = 12'h001;
      repeat (3) @(negedge core_clk);
      chk("range", {chan_is_current, range_conflict}, 48'h1d);
      for (int m = 0; m < 5; m++)
      begin
         range_cfg = {9'h124, m[2:0]};
         repeat (3) @(negedge core_clk);
         chk("range", {chan_is_current, range_conflict}, {m == 0, 1'b0});
      end
      complete_run();
   end
endmodule

// ===== hdl/qdud_chan.sv
// Purpose: one output channel sample holder
// Assumes: load strobe and sample come from the same word
// Notes:   holds value while not loaded
`timescale 1ns/1ps
`include "qdud_consts.svh"
module qdud_chan
   import qdud_pkg::*;
(
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // load request
   input  wire logic         load,
   input  wire qdud_sample_t sample,
   // held value
   output qdud_sample_t      value
);
   typedef struct packed
   {
      qdud_sample_t value;
   } qdud_chan_s;

   qdud_chan_s st_reg;
   qdud_chan_s st_next;

   always_comb
   begin
      st_next = st_reg;
      if (load)
         st_next.value = sample;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         st_reg.value <= `QDUD_SAMPLE_RST;
      else
         st_reg <= st_next;
   end

   assign value = st_reg.value;
endmodule

// ===== hdl/qdud_consts.svh
// Purpose: named constants for the quad output update word decoder
// Assumes: 16-bit update word, four channels, 12-bit samples
// Notes:   definitions only
`ifndef QDUD_CONSTS_SVH
`define QDUD_CONSTS_SVH
`define QDUD_WORD_W      16
`define QDUD_DATA_W      12
`define QDUD_DATA_LSB    0
`define QDUD_DATA_MSB    11
`define QDUD_SEL_LSB     12
`define QDUD_SEL_MSB     15
`define QDUD_NCHAN       4
`define QDUD_CODE_MAX    12'hfff
`define QDUD_CODE_ZERO   12'h000
`define QDUD_SPAN_STEPS  13'h0fff
`define QDUD_SAMPLE_RST  12'h000
`define QDUD_RANGE_W     3
`define QDUD_RANGE_4_20MA 3'h0
`define QDUD_RANGE_BIP10  3'h1
`define QDUD_RANGE_BIP5   3'h2
`define QDUD_RANGE_UNI5   3'h3
`define QDUD_RANGE_UNI10  3'h4
`define QDUD_RANGE_RST    12'h000
`define QDUD_SEL_CH1      12
`define QDUD_SEL_CH2      13
`define QDUD_SEL_CH3      14
`define QDUD_SEL_CH4      15
`define QDUD_CH1          0
`define QDUD_CH2          1
`define QDUD_CH3          2
`define QDUD_CH4          3
`define QDUD_WORD_RST     16'hffff
`define QDUD_FLAGS_CLR    4'h0
`define QDUD_CURRENT_RST  4'hf
`define QDUD_CONFLICT_RST 1'h0
`endif

// ===== hdl/qdud_pkg.sv
// Purpose: types for the quad output update word decoder
// Assumes: constants header supplies widths
// Notes:   types only
`include "qdud_consts.svh"
package qdud_pkg;
   typedef logic [`QDUD_DATA_W-1:0]  qdud_sample_t;
   typedef logic [`QDUD_WORD_W-1:0]  qdud_word_t;
   typedef logic [`QDUD_RANGE_W-1:0] qdud_range_t;
   typedef enum logic [1:0]
   {
      QDUD_IDLE  = 2'b01,
      QDUD_APPLY = 2'b10
   } qdud_state_e;
endpackage

// ===== hdl/qdud_top.sv
// Purpose: decode the 16-bit channel update word into four held samples
// Assumes: word and strobe come from host logic on core_clk
// Notes:   range codes are static configuration, decoded for status only
//          a bipolar ten volt and current mix is flagged, not blocked
//          codes change one clock after the strobe edge
//          selects are active low: a cleared bit loads its channel
//
// How it works
// - the sixteen output bits form one word carrying sample and channel selects.
// - word bits 12 to 15 select channels 1 to 4, one bit each.
// - on an update each channel with a cleared select bit loads the 12-bit sample.
// - a channel with its select bit set keeps its last sample.
// - word bits 0 to 11 are an unsigned code from 000 to fff hex.
// - code 0 maps to the range low limit and code fff to the high limit.
// - channels may be updated in any order on any update.
// - one code step is the range span divided by 4095.
// - after reset every channel's range is the 4 to 20 mA current range.
`timescale 1ns/1ps
`include "qdud_consts.svh"
module qdud_top
   import qdud_pkg::*;
(
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // update word from host
   input  wire qdud_word_t    channel_update_word,
   input  wire logic          update_strobe,
   // range configuration, three bits per channel
   input  wire logic [11:0]   range_cfg,
   // channel samples to converters
   output qdud_sample_t       chan1_code,
   output qdud_sample_t       chan2_code,
   output qdud_sample_t       chan3_code,
   output qdud_sample_t       chan4_code,
   // status
   output logic [3:0]         chan_loaded,
   output logic [3:0]         chan_is_current,
   output logic               range_conflict
);
   typedef struct packed
   {
      qdud_state_e  state;
      qdud_word_t   word;
      logic [3:0]   loaded;
      logic [3:0]   is_current;
      logic         conflict;
      logic [11:0]  range;
   } qdud_top_s;

   // decoder state except the held samples in one register
   qdud_top_s st_reg;
   qdud_top_s st_next;

   // select bits as the host sees them
   logic         chan1_hold_select;
   logic         chan2_hold_select;
   logic         chan3_hold_select;
   logic         chan4_hold_select;
   logic [3:0]   hold_vec;
   logic [3:0]   load_vec;
   logic         applying;
   qdud_sample_t sample;
   qdud_sample_t code_vec [`QDUD_NCHAN];

   // registered range of each channel
   qdud_range_t  range_ch1;
   qdud_range_t  range_ch2;
   qdud_range_t  range_ch3;
   qdud_range_t  range_ch4;
   logic [3:0]   cur_vec;
   logic [3:0]   bip10_vec;

   // range field of one channel
   function automatic qdud_range_t range_of(input logic [11:0] cfg, input int idx);
      range_of = cfg[idx*`QDUD_RANGE_W +: `QDUD_RANGE_W];
   endfunction

   // current loop range test
   function automatic logic range_is_current(input qdud_range_t code);
      range_is_current = (code == `QDUD_RANGE_4_20MA);
   endfunction

   // bipolar ten volt range test
   function automatic logic range_is_bip10(input qdud_range_t code);
      range_is_bip10 = (code == `QDUD_RANGE_BIP10);
   endfunction

   // one select bit of a word
   function automatic logic sel_bit(input qdud_word_t word, input int pos);
      sel_bit = word[pos];
   endfunction

   // data field of a word
   function automatic qdud_sample_t data_of(input qdud_word_t word);
      data_of = word[`QDUD_DATA_MSB:`QDUD_DATA_LSB];
   endfunction

   assign sample = data_of(st_reg.word);

   assign chan1_hold_select = sel_bit(st_reg.word, `QDUD_SEL_CH1);
   assign chan2_hold_select = sel_bit(st_reg.word, `QDUD_SEL_CH2);
   assign chan3_hold_select = sel_bit(st_reg.word, `QDUD_SEL_CH3);
   assign chan4_hold_select = sel_bit(st_reg.word, `QDUD_SEL_CH4);
   assign hold_vec          = {chan4_hold_select, chan3_hold_select, chan2_hold_select, chan1_hold_select};

   assign applying = (st_reg.state == QDUD_APPLY);
   assign load_vec = applying ? ~hold_vec : `QDUD_FLAGS_CLR;

   // per channel range fields
   assign range_ch1 = range_of(st_reg.range, `QDUD_CH1);
   assign range_ch2 = range_of(st_reg.range, `QDUD_CH2);
   assign range_ch3 = range_of(st_reg.range, `QDUD_CH3);
   assign range_ch4 = range_of(st_reg.range, `QDUD_CH4);

   assign cur_vec = {range_is_current(range_ch4),
                     range_is_current(range_ch3),
                     range_is_current(range_ch2),
                     range_is_current(range_ch1)};

   assign bip10_vec = {range_is_bip10(range_ch4),
                       range_is_bip10(range_ch3),
                       range_is_bip10(range_ch2),
                       range_is_bip10(range_ch1)};

   always_comb
   begin
      st_next            = st_reg;

      st_next.loaded     = load_vec;

      unique case (st_reg.state)
         QDUD_IDLE:
         begin
            if (update_strobe)
            begin
               st_next.word  = channel_update_word;
               st_next.state = QDUD_APPLY;
            end
            else
            begin
               st_next.state = QDUD_IDLE;
            end
         end
         QDUD_APPLY:
         begin
            if (update_strobe)
            begin
               st_next.word  = channel_update_word;
               st_next.state = QDUD_APPLY;
            end
            else
            begin
               st_next.state = QDUD_IDLE;
            end
         end
         default:
            st_next.state = QDUD_IDLE;
      endcase

      // range captured every cycle
      st_next.range      = range_cfg;

      st_next.is_current = cur_vec;

      st_next.conflict   = `QDUD_CONFLICT_RST;
      if ((|bip10_vec) && (|cur_vec))
         st_next.conflict = 1'h1;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_reg.state      <= QDUD_IDLE;
         st_reg.word       <= `QDUD_WORD_RST;
         st_reg.loaded     <= `QDUD_FLAGS_CLR;
         st_reg.is_current <= `QDUD_CURRENT_RST;
         st_reg.conflict   <= `QDUD_CONFLICT_RST;
         st_reg.range      <= `QDUD_RANGE_RST;
      end
      else
         st_reg <= st_next;
   end

   for (genvar g = 0; g < `QDUD_NCHAN; g++)
   begin : g_chan
      qdud_chan qdud_chan_i
      (
         .core_clk (core_clk),
         .rst      (rst),
         .load     (load_vec[g]),
         .sample   (sample),
         .value    (code_vec[g])
      );
   end

   // converter codes straight from holders
   assign chan1_code      = code_vec[`QDUD_CH1];
   assign chan2_code      = code_vec[`QDUD_CH2];
   assign chan3_code      = code_vec[`QDUD_CH3];
   assign chan4_code      = code_vec[`QDUD_CH4];

   // status straight from the state register
   assign chan_loaded     = st_reg.loaded;
   assign chan_is_current = st_reg.is_current;
   assign range_conflict  = st_reg.conflict;
endmodule
